// File: hdl/sslp_defines.svh
// sslp_defines.svh: timing counts and widths for the sram sleep controller
// assumes: included by bare name from design files only
`ifndef SSLP_DEFINES_SVH
`define SSLP_DEFINES_SVH
`define SSLP_CLK_PERIOD_PS 4000
`define SSLP_ENTRY_CYCLES 2
`define SSLP_RECOVERY_PS 20000
// least time rounds up to whole cycles
`define SSLP_RECOVERY_CYCLES ((`SSLP_RECOVERY_PS + `SSLP_CLK_PERIOD_PS - 1) / `SSLP_CLK_PERIOD_PS)
`define SSLP_CNT_W 4
`endif

// File: hdl/sslp_pkg.sv
// sslp_pkg.sv: types for the sram sleep controller
// assumes: used with package-qualified names, nothing imported
package sslp_pkg;
  typedef enum logic [3:0] {
    SSLP_AWAKE = 4'h1,
    SSLP_ENTER = 4'h2,
    SSLP_SLEEP = 4'h4,
    SSLP_RECOV = 4'h8
  } sslp_state_t;
endpackage : sslp_pkg

// File: hdl/sslp_data_store.sv
// sslp_data_store.sv: small synchronous memory with registered read data
// assumes: single clock, contents are not reset
`timescale 1ns/1ps
module sslp_data_store #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  input wire logic sys_clk_i, // device clock
  input wire logic we_i, // write strobe
  input wire logic re_i, // read strobe
  input wire logic [AW-1:0] addr_i, // word address
  input wire logic [DW-1:0] wdata_i, // write data
  output logic [DW-1:0] rdata_o // registered read data
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // contents hold across sleep since nothing clears them
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_o <= mem_q[addr_i];
    end
  end
endmodule : sslp_data_store

// File: hdl/sslp_ctrl.sv
// sslp_ctrl.sv: sync burst sram core with sleep entry, hold and recovery
// assumes: sleep request arrives from a pin in another timing domain;
// commands come from logic on sys_clk_i
// limits: the recovery load must fit the cycle counter width
// a request that returns during recovery goes straight back to entry
// the pin is seen two flops late, so entry and exit both lag it by
// two cycles on top of the counted intervals
// reads stay legal in recovery; writes there are dropped and flagged
//
// Contract
// - enter sleep two cycles after request
// - all internal state kept while asleep
// - resume only after 20 ns recovery; an entry begun in recovery that aborts goes to awake without it
// - asleep: ignore inputs, float all outputs; only dq floats here, status outputs stay driven
// - deselected for whole time request high; here deselection follows the synchronised request, two cycles behind the pin
// - sleep request asynchronous, active high
`timescale 1ns/1ps
`include "sslp_defines.svh"
module sslp_ctrl #(
  parameter int AW = 4,
  parameter int DW = 16,
  parameter int RECOVERY_CYCLES = `SSLP_RECOVERY_CYCLES
) (
  input wire logic sys_clk_i, // device clock, 250 MHz
  input wire logic rst_n_i, // async reset, active low
  input wire logic sleep_request_i, // async sleep pin, active high
  input wire logic sel_i, // chip select, same clock
  input wire logic start_i, // load new address
  input wire logic adv_i, // advance burst counter
  input wire logic wr_i, // write command
  input wire logic [AW-1:0] addr_i, // start address
  input wire logic [DW-1:0] wdata_i, // write data
  output logic [DW-1:0] dq_o, // read data
  output logic dq_oe_n_o, // low while driving dq
  output logic asleep_o, // sleep state reached
  output logic recovering_o, // in recovery interval
  output logic write_refused_o // write seen during recovery
);
  // counter width kept as a plain constant so casts stay readable
  localparam int CNT_W = `SSLP_CNT_W;
  // loads for the down counter, which ends each span at zero
  localparam int ENTRY_LOAD = `SSLP_ENTRY_CYCLES - 1;
  localparam int RECOV_LOAD = RECOVERY_CYCLES - 1;

  // state decode shared by the command gating and the status flags
  function automatic logic is_sleep(input sslp_pkg::sslp_state_t s);
    return (s == sslp_pkg::SSLP_SLEEP);
  endfunction : is_sleep

  function automatic logic is_recov(input sslp_pkg::sslp_state_t s);
    return (s == sslp_pkg::SSLP_RECOV);
  endfunction : is_recov

  // pin passes two flops; first flop read only by second
  logic req_meta_q, req_sync_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= sleep_request_i;
      req_sync_q <= req_meta_q;
    end
  end

  // one-hot state plus one down counter shared by both timed spans
  sslp_pkg::sslp_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  // next state; request level alone decides sleep span
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      // awake: a synchronised request starts the entry count
      sslp_pkg::SSLP_AWAKE: begin
        if (req_sync_q) begin
          state_d = sslp_pkg::SSLP_ENTER;
          cnt_d = CNT_W'(ENTRY_LOAD);
        end
      end
      // entering: a request that drops early aborts back to awake
      sslp_pkg::SSLP_ENTER: begin
        if (!req_sync_q) begin
          state_d = sslp_pkg::SSLP_AWAKE;
        end else if (cnt_q == '0) begin
          state_d = sslp_pkg::SSLP_SLEEP;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      // asleep: held for exactly as long as the request stays high
      sslp_pkg::SSLP_SLEEP: begin
        if (!req_sync_q) begin
          state_d = sslp_pkg::SSLP_RECOV;
          cnt_d = CNT_W'(RECOV_LOAD);
        end
      end
      // recovering: counts out the interval before full service
      sslp_pkg::SSLP_RECOV: begin
        if (req_sync_q) begin
          state_d = sslp_pkg::SSLP_ENTER;
          cnt_d = CNT_W'(ENTRY_LOAD);
        end else if (cnt_q == '0) begin
          state_d = sslp_pkg::SSLP_AWAKE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = sslp_pkg::SSLP_AWAKE;
      end
    endcase
  end

  // state and counter registers; reset lands awake
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= sslp_pkg::SSLP_AWAKE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // command gating; synchronised request high means deselected at once
  // decodes of the current state
  wire asleep_w = is_sleep(state_q);
  wire recov_w = is_recov(state_q);
  wire live_w = !asleep_w && !req_sync_q;
  wire cmd_sel_w = live_w && sel_i;
  // writes in recovery are dropped rather than risk a corrupt cell
  wire wr_ok_w = cmd_sel_w && wr_i && !recov_w;
  wire wr_bad_w = cmd_sel_w && wr_i && recov_w;
  wire rd_w = cmd_sel_w && !wr_i;

  // burst counter only moves on live commands; held while asleep
  logic [AW-1:0] burst_q;
  wire [AW-1:0] burst_inc_w = burst_q + 1'b1; // wraps at the top word
  wire [AW-1:0] burst_d = start_i ? addr_i : (adv_i ? burst_inc_w : burst_q);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_q <= '0;
    end else if (cmd_sel_w) begin
      burst_q <= burst_d;
    end
  end

  // store follows the burst mux, so a load and its access share a cycle
  logic [DW-1:0] rdata_w;
  sslp_data_store #(.AW(AW), .DW(DW)) u_store (
    .sys_clk_i(sys_clk_i),
    .we_i(wr_ok_w),
    .re_i(rd_w),
    .addr_i(burst_d),
    .wdata_i(wdata_i),
    .rdata_o(rdata_w)
  );

  // read valid one cycle after the store registers its data
  logic rd_pend_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= rd_w;
    end
  end

  // output stage; floats whenever asleep or request seen
  wire drive_w = rd_pend_q && live_w;
  wire asleep_nx_w = is_sleep(state_d);
  wire recov_nx_w = is_recov(state_d);

  // read data holds its last value between reads
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_o <= '0;
    end else if (drive_w) begin
      dq_o <= rdata_w;
    end
  end

  // enable idles high, so reset and sleep leave dq floating
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_oe_n_o <= 1'b1;
    end else begin
      dq_oe_n_o <= !drive_w;
    end
  end

  // taken from the next state so the flag lines up with state_q
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      asleep_o <= 1'b0;
    end else begin
      asleep_o <= asleep_nx_w;
    end
  end

  // level for the whole counted recovery
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      recovering_o <= 1'b0;
    end else begin
      recovering_o <= recov_nx_w;
    end
  end

  // one-cycle pulse per write dropped in recovery
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_refused_o <= 1'b0;
    end else begin
      write_refused_o <= wr_bad_w;
    end
  end
endmodule : sslp_ctrl

// File: tb/sslp_ctrl_sva.sv
// sslp_ctrl_sva.sv: port-level checks for the sram sleep controller
// assumes: bound to sslp_ctrl, all ports read only
`timescale 1ns/1ps
module sslp_ctrl_sva #(parameter int AW = 4, parameter int DW = 16,
  parameter int RECOVERY_CYCLES = 5) (
  input wire logic sys_clk_i, rst_n_i, sleep_request_i, sel_i, start_i, adv_i, wr_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i, dq_o,
  input wire logic dq_oe_n_o, asleep_o, recovering_o, write_refused_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] rec_n_q;
  // recovery length counted here, a repetition cannot take a parameter
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i) rec_n_q <= 4'h0;
    else rec_n_q <= recovering_o ? rec_n_q + 4'h1 : 4'h0;
  sequence s_req_held; sleep_request_i [*7]; endsequence
  // pin low three samples keeps the synchronised request low as well
  sequence s_read_taken;
    !sleep_request_i [*3] ##0 (sel_i && !wr_i && !asleep_o && !recovering_o);
  endsequence
  // entry bounded both ways, sleep state floats and freezes the core
  a_entry_not_early: assert property ($rose(sleep_request_i) |=> !asleep_o [*2])
    else $error("sleep entered too early");
  a_entry_reached: assert property (s_req_held |-> asleep_o)
    else $error("sleep not entered");
  a_float_asleep: assert property (asleep_o |-> dq_oe_n_o)
    else $error("output driven while asleep");
  a_sleep_held: assert property (sleep_request_i && asleep_o |=> asleep_o)
    else $error("sleep left while request high");
  a_read_ignored: assert property (asleep_o && sel_i && !wr_i |-> ##3 dq_oe_n_o)
    else $error("read taken while asleep");
  a_recov_length: assert property ($fell(recovering_o) |-> rec_n_q == RECOVERY_CYCLES)
    else $error("recovery length wrong");
  a_write_refused: assert property (recovering_o && sel_i && wr_i |=> write_refused_o)
    else $error("recovery write not refused");
  a_read_answer: assert property (s_read_taken |-> ##2 !dq_oe_n_o)
    else $error("read answer missing");
endmodule : sslp_ctrl_sva

// File: tb/sslp_host_model.sv
// sslp_host_model.sv: host controller driving the sram command pins
// assumes: bench calls the tasks, one command per clock
`timescale 1ns/1ps
module sslp_host_model (
  input wire logic sys_clk_i, // device clock
  output logic sleep_request_o, // sleep pin
  output logic sel_o, wr_o, start_o, adv_o, // command strobes
  output logic [3:0] addr_o, // address
  output logic [15:0] wdata_o // write data
);
  // request low from the start, pull-down level
  initial {sleep_request_o, sel_o, wr_o, start_o, adv_o, addr_o, wdata_o} = '0;
  // c is {sel, wr, start, adv}; bench drains reads before sleeping
  task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    {sel_o, wr_o, start_o, adv_o, addr_o, wdata_o} <= {c, a, d};
  endtask : cmd
  // unselected bus is scrambled, the device must not look at it
  task automatic idle();
    cmd(4'h0, ~addr_o, ~wdata_o);
  endtask : idle
  task automatic sleep(input logic v);
    @(posedge sys_clk_i);
    sleep_request_o <= v;
  endtask : sleep
endmodule : sslp_host_model

// File: tb/sram_sleep_mode_control_bench.sv
// sram_sleep_mode_control_bench.sv: fill, sleep, recover, read back
// assumes: host model drives every command pin
`timescale 1ns/1ps
module sram_sleep_mode_control_bench;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  wire logic sleep_request_i, sel_i, wr_i, start_i, adv_i;
  wire logic [3:0] addr_i;
  wire logic [15:0] wdata_i;
  logic [15:0] dq_o;
  logic dq_oe_n_o, asleep_o, recovering_o, write_refused_o;
  int error_cnt = 0;
  int n_tests = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  sslp_host_model h (.sys_clk_i, .sleep_request_o(sleep_request_i), .sel_o(sel_i),
    .wr_o(wr_i), .start_o(start_i), .adv_o(adv_i), .addr_o(addr_i), .wdata_o(wdata_i));
  sslp_ctrl #(.RECOVERY_CYCLES(5)) dut (.sys_clk_i, .rst_n_i, .sleep_request_i, .sel_i,
    .start_i, .adv_i, .wr_i, .addr_i, .wdata_i, .dq_o, .dq_oe_n_o, .asleep_o,
    .recovering_o, .write_refused_o);
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // addr 6 by load, addr 7 by advance, read 7 leaves counter at 7
  task automatic t_fill();
    h.cmd(4'hE, 4'h6, 16'hA1C3);
    h.cmd(4'hD, 4'h0, 16'h5E7B);
    h.cmd(4'hA, 4'h7, 16'h0000);
    h.idle();
    repeat (3) @(posedge sys_clk_i);
    #1 check("fill", dq_o, 16'h5E7B);
  endtask : t_fill
  // commands while asleep must change nothing
  task automatic t_sleep();
    h.sleep(1'b1);
    for (int i = 0; i < 12 && asleep_o !== 1'b1; i++) @(posedge sys_clk_i);
    h.cmd(4'hE, 4'h6, 16'hBAD0);
    h.cmd(4'hA, 4'h9, 16'h0000);
    h.idle();
    repeat (3) @(posedge sys_clk_i);
    #1 check("float", dq_oe_n_o, 16'h0001);
    check("asleep", asleep_o, 16'h0001);
  endtask : t_sleep
  // write in recovery is dropped, then counter and memory read back
  task automatic t_wake();
    h.sleep(1'b0);
    for (int i = 0; i < 12 && recovering_o !== 1'b1; i++) @(posedge sys_clk_i);
    h.cmd(4'hC, 4'h0, 16'h0F0F);
    h.idle();
    #1 check("refused", write_refused_o, 16'h0001);
    for (int i = 0; i < 12 && recovering_o !== 1'b0; i++) @(posedge sys_clk_i);
    h.cmd(4'h8, 4'h0, 16'h0000);
    h.cmd(4'hA, 4'h6, 16'h0000);
    h.idle();
    #1 check("ctr", dq_o, 16'h5E7B);
    check("drive", dq_oe_n_o, 16'h0000);
    @(posedge sys_clk_i);
    #1 check("mem", dq_o, 16'hA1C3);
  endtask : t_wake
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_fill();
    t_sleep();
    t_wake();
    tally_and_finish();
  end
  // watchdog: run needs about forty cycles
  initial begin
    #4000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : sram_sleep_mode_control_bench
bind sslp_ctrl sslp_ctrl_sva #(.AW(AW), .DW(DW), .RECOVERY_CYCLES(RECOVERY_CYCLES)) chk (
  .sys_clk_i, .rst_n_i, .sleep_request_i, .sel_i, .start_i, .adv_i, .wr_i, .addr_i,
  .wdata_i, .dq_o, .dq_oe_n_o, .asleep_o, .recovering_o, .write_refused_o);
